/* File: hdl/encoder_preset_param_access.sv */
// Preset engine and single-parameter request interpreter, AXI4-Lite slave.
// Assumes cyclic words are written by the bus-side agent once per I/O cycle.
//
// Overview of operation
// [RULE1] Preset request loads reported position
// [RULE2] Controller configures resolution before presetting
// [RULE3] Offset computed, kept in non-volatile store
// [RULE4] Range change clears stored offset
// [RULE5] Bit 31 requests, bits 30..0 value
// [RULE6] Controller holds request one full cycle
// [RULE7] Only rising request edge triggers preset
// [RULE8] Controller clears request after completion
// [RULE9] Profile preset needs PLC control flag
// [RULE10] Relative select shifts, absolute loads
// [RULE11] Profile edge starts; acknowledge held while requested
// [RULE12] Profile value from 65000, two's complement
// [RULE13] Acyclic and cyclic paths run independently
// [RULE14] Identification record read-only at AFF0
// [RULE15] Request: header, address, value; 1 read 2 write
// [RULE16] Read ignores index, attribute, count, format
// [RULE17] Reference and identifier mirrored into response
// [RULE18] One parameter, at most 240 bytes
// [RULE19] Recognise 922-980, 61000-61004, 65000-65001
// [RULE20] Telegram type read-only, valid configured formats
// [RULE21] Telegrams 101/102 add 16/32-bit speed; code only stores the telegram type and outputs no speed word
// [RULE22] Acknowledge clears with request
// [RULE23] Bad number or identifier gives error response
`default_nettype none
module encoder_preset_param_access (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Process data out
	output logic [31:0] position,
	output logic preset_acknowledge_flag
);
	import preset_param_pkg::*;

	logic [31:0] ctrl_q, std_out_q, ctl_words_q, preset_param_q, raw_pos_q;
	logic [31:0] offset_q, range_q, req_hdr_q, req_addr_q, req_val_q;
	logic [31:0] rsp_hdr_q, rsp_val_q;
	logic [7:0] telegram_q;
	logic [3:0] im_idx_q;
	logic aw_got_q, w_got_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic std_req_q, pr_req_q, preset_start, preset_is_profile_q;
	preset_state_e state_q;
	logic [31:0] new_offset_q, nv_rd;
	logic nv_wr, nv_busy, range_clear_q;
	logic wr_fire;
	logic [15:0] pnum;
	logic [7:0] rid;
	logic [15:0] sensor_control_word, second_control_word;

	assign sensor_control_word = ctl_words_q[15:0];
	assign second_control_word = ctl_words_q[31:16];

	// Write channel: address and data in either order
	assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_got_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_q > OFF_IM_WORD || aw_addr_q[1:0] != 2'b00)
					? 2'b10 : 2'b00;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
			end
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Software-written words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= 32'h0000_0000;
			std_out_q <= 32'h0000_0000;
			ctl_words_q <= 32'h0000_0000;
			preset_param_q <= 32'h0000_0000;
			raw_pos_q <= 32'h0000_0000;
			req_hdr_q <= 32'h0000_0000;
			req_addr_q <= 32'h0000_0000;
			req_val_q <= 32'h0000_0000;
			im_idx_q <= 4'h0;
		end else begin
			ctrl_q[CTRL_REQ_GO_BIT] <= 1'b0;
			if (wr_fire) begin
				case (aw_addr_q)
					OFF_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
					OFF_STD_OUT: std_out_q <= merge(std_out_q, w_data_q, w_strb_q);
					OFF_CTL_WORDS: ctl_words_q <= merge(ctl_words_q, w_data_q, w_strb_q);
					OFF_RAW_POS: raw_pos_q <= merge(raw_pos_q, w_data_q, w_strb_q);
					OFF_REQ_HDR: req_hdr_q <= merge(req_hdr_q, w_data_q, w_strb_q);
					OFF_REQ_ADDR: req_addr_q <= merge(req_addr_q, w_data_q, w_strb_q);
					OFF_REQ_VAL: req_val_q <= merge(req_val_q, w_data_q, w_strb_q);
					OFF_IM_WORD: im_idx_q <= w_data_q[3:0];
					default: begin
					end
				endcase
			end
			// Parameter write of 65000 lands in the preset word
			if (ctrl_q[CTRL_REQ_GO_BIT] && rid == REQ_WRITE && pnum == P_PRESET) begin
				preset_param_q <= req_val_q; // RULE12
			end
		end
	end

	// Range register; change arms offset clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			range_q <= RST_RANGE;
			range_clear_q <= 1'b0;
		end else begin
			range_clear_q <= 1'b0;
			if (wr_fire && aw_addr_q == OFF_RANGE) begin
				range_q <= merge(range_q, w_data_q, w_strb_q);
				range_clear_q <= (merge(range_q, w_data_q, w_strb_q) != range_q); // RULE4
			end
		end
	end

	// Telegram type: fixed by configuration, not writable by request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			telegram_q <= RST_TELEGRAM;
		end else if (wr_fire && aw_addr_q == OFF_TELEGRAM) begin
			if ((w_data_q[7:0] >= 8'd100 && w_data_q[7:0] <= 8'd102) ||
				(w_data_q[7:0] >= 8'd81 && w_data_q[7:0] <= 8'd83)) begin
				telegram_q <= w_data_q[7:0]; // RULE20
			end
		end
	end

	// Edge detection on both request sources
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			std_req_q <= 1'b0;
			pr_req_q <= 1'b0;
		end else begin
			std_req_q <= std_out_q[STD_PRESET_BIT];
			pr_req_q <= sensor_control_word[STW1_PR_BIT];
		end
	end
	// Edge only, so a held request never repeats
	assign preset_start = (state_q == PR_IDLE) && (ctrl_q[CTRL_PROFILE_BIT]
		? (sensor_control_word[STW1_PR_BIT] && !pr_req_q
			&& second_control_word[SECOND_CONTROL_WORD_PLC_BIT]) // RULE7 RULE9 RULE11
		: (std_out_q[STD_PRESET_BIT] && !std_req_q)); // RULE5 RULE7

	// Preset sequence; store step waits only for an earlier flash write to finish
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= PR_IDLE;
			new_offset_q <= 32'h0000_0000;
			preset_is_profile_q <= 1'b0;
		end else begin
			case (state_q)
				PR_IDLE: begin
					if (preset_start) begin
						preset_is_profile_q <= ctrl_q[CTRL_PROFILE_BIT];
						state_q <= PR_CALC;
					end
				end
				PR_CALC: begin
					if (!preset_is_profile_q) begin
						new_offset_q <= {1'b0, std_out_q[30:0]} - raw_pos_q; // RULE1 RULE5
					end else if (sensor_control_word[STW1_REL_BIT]) begin
						new_offset_q <= offset_q + preset_param_q; // RULE10 RULE12
					end else begin
						new_offset_q <= preset_param_q - raw_pos_q; // RULE10
					end
					state_q <= PR_STORE;
				end
				PR_STORE: begin
					if (!nv_busy) begin
						state_q <= PR_DONE;
					end
				end
				PR_DONE: state_q <= PR_IDLE;
				default: state_q <= PR_IDLE;
			endcase
		end
	end

	assign nv_wr = (state_q == PR_STORE && !nv_busy) || range_clear_q; // RULE3

	nv_offset_store u_nv (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(nv_wr),
		.wr_data(range_clear_q ? 32'h0000_0000 : new_offset_q),
		.rd_data(nv_rd),
		.busy(nv_busy)
	);

	// Live offset; store keeps the committed copy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			offset_q <= 32'h0000_0000;
		end else if (range_clear_q) begin
			offset_q <= 32'h0000_0000; // RULE4
		end else if (state_q == PR_DONE) begin
			offset_q <= new_offset_q; // RULE3
		end
	end

	// Reported position and acknowledge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			position <= 32'h0000_0000;
			preset_acknowledge_flag <= 1'b0;
		end else begin
			position <= raw_pos_q + offset_q; // RULE1
			if (!sensor_control_word[STW1_PR_BIT]) begin
				preset_acknowledge_flag <= 1'b0; // RULE22
			end else if (state_q == PR_DONE && preset_is_profile_q) begin
				preset_acknowledge_flag <= 1'b1; // RULE11
			end
		end
	end

	// Request interpreter, separate from cyclic path
	assign rid = req_hdr_q[15:8];
	assign pnum = req_addr_q[31:16];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rsp_hdr_q <= 32'h0000_0000;
			rsp_val_q <= 32'h0000_0000;
		end else if (ctrl_q[CTRL_REQ_GO_BIT]) begin // RULE13
			// Header: ref, id, object 0, one parameter
			rsp_hdr_q <= {16'h0001, rid, req_hdr_q[7:0]}; // RULE17 RULE18
			rsp_val_q <= 32'h0000_0000;
			if ((rid != REQ_READ && rid != REQ_WRITE) || !((pnum >= P_PROF_LO && pnum <= P_PROF_HI)
				|| (pnum >= P_IF_LO && pnum <= P_IF_HI) || pnum == P_PRESET
				|| pnum == P_OPSTAT) || (rid == REQ_WRITE && pnum == P_TELEGRAM)) begin
				rsp_hdr_q <= {16'h0001, rid | RSP_ERROR_BIT, req_hdr_q[7:0]}; // RULE23 RULE19
			end else if (rid == REQ_READ) begin // RULE15 RULE16
				case (pnum)
					P_TELEGRAM: rsp_val_q <= {24'h000000, telegram_q}; // RULE20 RULE21
					P_PRESET: rsp_val_q <= preset_param_q;
					P_OPSTAT: rsp_val_q <= {24'h000000, MAX_ACCESS_BYTES};
					default: rsp_val_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Identification record, read-only
	function automatic logic [31:0] im_word(input logic [3:0] i);
		case (i)
			4'h0: im_word = {16'h0020, 16'h0038};
			4'h1: im_word = {16'h0100, IM_MAKER_ID};
			4'h2: im_word = {16'h0002, IM_RECORD_INDEX}; // RULE14
			default: im_word = 32'h0000_0000;
		endcase
	endfunction : im_word

	// Read channel: one-cycle registered answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
					OFF_CTRL: s_axi_rdata <= ctrl_q;
					OFF_STATUS: s_axi_rdata <= {19'h0, preset_acknowledge_flag, 8'h0,
						state_q};
					OFF_STD_OUT: s_axi_rdata <= std_out_q;
					OFF_CTL_WORDS: s_axi_rdata <= ctl_words_q;
					OFF_PRESET_PARAM: s_axi_rdata <= preset_param_q;
					OFF_RAW_POS: s_axi_rdata <= raw_pos_q;
					OFF_POSITION: s_axi_rdata <= position;
					OFF_OFFSET: s_axi_rdata <= offset_q;
					OFF_RANGE: s_axi_rdata <= range_q;
					OFF_REQ_HDR: s_axi_rdata <= req_hdr_q;
					OFF_REQ_ADDR: s_axi_rdata <= req_addr_q;
					OFF_REQ_VAL: s_axi_rdata <= req_val_q;
					OFF_RSP_HDR: s_axi_rdata <= rsp_hdr_q;
					OFF_RSP_VAL: s_axi_rdata <= rsp_val_q;
					OFF_TELEGRAM: s_axi_rdata <= {24'h0, telegram_q};
					OFF_IM_WORD: s_axi_rdata <= im_word(im_idx_q);
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	logic unused_nv;
	assign unused_nv = ^nv_rd;

	// Checks
	sequence s_std_edge;
		!ctrl_q[CTRL_PROFILE_BIT] && state_q == PR_IDLE && std_out_q[31] && !std_req_q;
	endsequence
	a_std_edge_start: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
		s_std_edge |=> state_q == PR_CALC) else $error("edge did not start preset");
	a_held_no_repeat: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
		std_out_q[STD_PRESET_BIT] && $past(std_out_q[STD_PRESET_BIT]) && !ctrl_q[0]
		&& state_q == PR_IDLE |=> state_q != PR_CALC)
		else $error("held request restarted preset");
	a_plc_gate: assert property (@(posedge aclk) disable iff (!aresetn) // RULE9
		ctrl_q[0] && !second_control_word[SECOND_CONTROL_WORD_PLC_BIT] && state_q == PR_IDLE
		|=> state_q != PR_CALC)
		else $error("preset without PLC control");
	a_ack_drop: assert property (@(posedge aclk) disable iff (!aresetn) // RULE22
		!sensor_control_word[STW1_PR_BIT] |=> !preset_acknowledge_flag)
		else $error("acknowledge stayed after request cleared");
	a_ack_set: assert property (@(posedge aclk) disable iff (!aresetn) // RULE11
		state_q == PR_DONE && preset_is_profile_q && sensor_control_word[12]
		|=> preset_acknowledge_flag) else $error("acknowledge not set");
	a_range_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
		range_clear_q |=> offset_q == 32'h0) else $error("offset not cleared");
	a_done_offset: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
		state_q == PR_DONE && !range_clear_q |=> offset_q == $past(new_offset_q))
		else $error("offset not taken");
	a_ref_mirror: assert property (@(posedge aclk) disable iff (!aresetn) // RULE17
		ctrl_q[CTRL_REQ_GO_BIT] |=> rsp_hdr_q[7:0] == $past(req_hdr_q[7:0]))
		else $error("reference not mirrored");
endmodule : encoder_preset_param_access
`default_nettype wire

/* File: hdl/nv_offset_store.sv */
// Small non-volatile store model holding the single preset offset word.
// Assumes write strobes from the same clock; read data registered.
`default_nettype none
module nv_offset_store (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write port
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	// Read port
	output logic [31:0] rd_data,
	output logic busy
);
	import preset_param_pkg::*;
	logic [31:0] cell_q;
	logic [2:0] cnt_q;

	// Contents survive reset, like flash
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			cell_q <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_data <= 32'h0000_0000;
		end else begin
			rd_data <= cell_q;
		end
	end

	// Busy models the program time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 3'h0;
		end else if (wr_en) begin
			cnt_q <= 3'(NV_WRITE_CYCLES);
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end
	assign busy = (cnt_q != 3'h0);
endmodule : nv_offset_store
`default_nettype wire

/* File: hdl/preset_param_pkg.sv */
// Package: constants for preset handling and acyclic parameter access.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register slave.
`default_nettype none
package preset_param_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_STD_OUT = 8'h08;
	localparam logic [7:0] OFF_CTL_WORDS = 8'h0C;
	localparam logic [7:0] OFF_PRESET_PARAM = 8'h10;
	localparam logic [7:0] OFF_RAW_POS = 8'h14;
	localparam logic [7:0] OFF_POSITION = 8'h18;
	localparam logic [7:0] OFF_OFFSET = 8'h1C;
	localparam logic [7:0] OFF_RANGE = 8'h20;
	localparam logic [7:0] OFF_REQ_HDR = 8'h24;
	localparam logic [7:0] OFF_REQ_ADDR = 8'h28;
	localparam logic [7:0] OFF_REQ_VAL = 8'h2C;
	localparam logic [7:0] OFF_RSP_HDR = 8'h30;
	localparam logic [7:0] OFF_RSP_VAL = 8'h34;
	localparam logic [7:0] OFF_TELEGRAM = 8'h38;
	localparam logic [7:0] OFF_IM_WORD = 8'h3C;
	// Field positions
	localparam int STD_PRESET_BIT = 31;
	localparam int CTRL_PROFILE_BIT = 0;
	localparam int CTRL_REQ_GO_BIT = 1;
	localparam int SECOND_CONTROL_WORD_PLC_BIT = 10;
	localparam int STW1_REL_BIT = 11;
	localparam int STW1_PR_BIT = 12;
	localparam int ZSW1_PA_BIT = 12;
	// Reset values
	localparam logic [31:0] RST_RANGE = 32'h0001_0000;
	localparam logic [7:0] RST_TELEGRAM = 8'h64;
	// Request identifiers and parameter numbers
	localparam logic [7:0] REQ_READ = 8'h01;
	localparam logic [7:0] REQ_WRITE = 8'h02;
	localparam logic [7:0] RSP_ERROR_BIT = 8'h80;
	localparam logic [15:0] P_TELEGRAM = 16'd922;
	localparam logic [15:0] P_PROF_LO = 16'd922;
	localparam logic [15:0] P_PROF_HI = 16'd980;
	localparam logic [15:0] P_IF_LO = 16'd61000;
	localparam logic [15:0] P_IF_HI = 16'd61004;
	localparam logic [15:0] P_PRESET = 16'd65000;
	localparam logic [15:0] P_OPSTAT = 16'd65001;
	localparam logic [15:0] IM_RECORD_INDEX = 16'hAFF0;
	localparam logic [7:0] MAX_ACCESS_BYTES = 8'd240;
	// Arbitrary neutral identity value
	localparam logic [15:0] IM_MAKER_ID = 16'h5A5A;
	// Flash commit time
	localparam int NV_WRITE_CYCLES = 4;
	localparam int IM_WORDS = 16;
	typedef enum logic [3:0] {
		PR_IDLE = 4'b0001,
		PR_CALC = 4'b0010,
		PR_STORE = 4'b0100,
		PR_DONE = 4'b1000
	} preset_state_e;
endpackage : preset_param_pkg
`default_nettype wire

/* File: test/encoder_preset_param_access_tb_top.sv */
// Testbench top: preset engine and parameter requests over AXI4-Lite.
// Assumes plc_model as bus master and raw position constant without a sensor.
`default_nettype none
module encoder_preset_param_access_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import preset_param_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, position;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic preset_acknowledge_flag;
	int error_cnt = 0;
	int check_count = 0;
	logic [31:0] seed = 32'h0001_20E4;
	logic [7:0] t_id [8] = '{REQ_READ, REQ_WRITE, REQ_READ, REQ_READ, 8'h03, REQ_READ,
		REQ_READ, REQ_WRITE};
	logic [15:0] t_num [8] = '{P_TELEGRAM, P_PRESET, P_PRESET, 16'd1000, P_TELEGRAM,
		P_IF_HI, P_PROF_HI, P_TELEGRAM};
	logic t_err [8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	always #5 aclk = ~aclk;
	encoder_preset_param_access encoder_preset_param_access_i (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .position, .preset_acknowledge_flag);
	plc_model plc_i (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic logic [31:0] rsp_hdr(logic [7:0] rf, logic [7:0] id, logic err);
		return {16'h0001, err ? (id | RSP_ERROR_BIT) : id, rf};
	endfunction : rsp_hdr
	task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (e !== g) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk_word
	task automatic chk_bit(input string n, input logic e, input logic g);
		check_count++;
		if (e !== g) begin
			error_cnt++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit
	task automatic reg_chk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		plc_i.rd(a, d, r);
		chk_word(n, e, d);
	endtask : reg_chk
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		plc_i.wr(a, d, r);
	endtask : w
	// Preset takes a few cycles and does not wait for the store commit; 50 is ample
	task automatic wait_pos(input logic [31:0] e);
		int n;
		n = 0;
		while (position !== e && n < 50) begin
			@(posedge aclk);
			n++;
		end
		chk_word("position", e, position);
	endtask : wait_pos
	task automatic stop_test();
		$display("Checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	// Whole run is well under a thousand cycles; 30000 means a hang
	initial begin
		repeat (30000) @(posedge aclk);
		error_cnt++;
		stop_test();
	end
	initial begin
		logic [31:0] raw, v, p, q, d;
		logic [1:0] resp;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		chk_word("position reset", 32'h0, position);
		chk_bit("ack reset", 1'b0, preset_acknowledge_flag);
		reg_chk("range", OFF_RANGE, RST_RANGE);
		reg_chk("telegram", OFF_TELEGRAM, {24'h0, RST_TELEGRAM});
		plc_i.rd(8'h40, d, resp);
		chk_word("unmapped resp", 32'h2, {30'h0, resp});
		chk_word("unmapped data", 32'h0, d);
		reg_chk("offset reset", OFF_OFFSET, 32'h0);
		raw = rnd();
		w(OFF_RAW_POS, raw);
		wait_pos(raw);
		// Range configured before any preset
		w(OFF_RANGE, RST_RANGE);
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 32'h7FFF_FFFF : rnd() & 32'h7FFF_FFFF;
			plc_i.std_request(v);
			wait_pos(v);
			reg_chk("offset", OFF_OFFSET, v - raw);
			w(OFF_STD_OUT, {1'b1, ~v[30:0]});
			repeat (20) @(posedge aclk);
			chk_word("held request", v, position);
			plc_i.std_clear();
		end
		w(OFF_RANGE, RST_RANGE + 32'h100);
		reg_chk("offset cleared", OFF_OFFSET, 32'h0);
		wait_pos(raw);
		// Profile mode: request without the control flag must be ignored
		p = rnd();
		plc_i.param_request(8'h5A, REQ_WRITE, P_PRESET, 16'h0, p);
		reg_chk("preset param p", OFF_PRESET_PARAM, p);
		w(OFF_CTL_WORDS, 32'h0000_1000);
		repeat (20) @(posedge aclk);
		chk_word("no plc flag", raw, position);
		chk_bit("no plc ack", 1'b0, preset_acknowledge_flag);
		w(OFF_CTL_WORDS, 32'h0400_0000);
		w(OFF_CTL_WORDS, 32'h0400_1000);
		wait_pos(p);
		repeat (3) @(posedge aclk);
		chk_bit("ack set", 1'b1, preset_acknowledge_flag);
		w(OFF_CTL_WORDS, 32'h0400_0000);
		repeat (3) @(posedge aclk);
		chk_bit("ack cleared", 1'b0, preset_acknowledge_flag);
		plc_i.param_request(8'hA5, REQ_WRITE, P_PRESET, 16'h0, 32'hFFFF_FFFF);
		w(OFF_CTL_WORDS, 32'h0400_1800);
		wait_pos(p - 32'h1);
		w(OFF_CTL_WORDS, 32'h0400_0000);
		// Acyclic requests: reads, writes, bad number, bad identifier
		q = rnd();
		for (int i = 0; i < 8; i++) begin
			d = rnd();
			plc_i.param_request(d[7:0], t_id[i], t_num[i], d[31:16], q);
			reg_chk("response header", OFF_RSP_HDR, rsp_hdr(d[7:0], t_id[i], t_err[i]));
			if (i == 0) reg_chk("telegram value", OFF_RSP_VAL, {24'h0, RST_TELEGRAM});
			if (i == 2) reg_chk("preset value", OFF_RSP_VAL, q);
		end
		reg_chk("preset param", OFF_PRESET_PARAM, q);
		reg_chk("telegram kept", OFF_TELEGRAM, {24'h0, RST_TELEGRAM});
		w(OFF_IM_WORD, 32'h0);
		reg_chk("ident header", OFF_IM_WORD, {16'h0020, 16'h0038});
		w(OFF_IM_WORD, 32'h2);
		reg_chk("ident index", OFF_IM_WORD, {16'h0002, IM_RECORD_INDEX});
		chk_word("position undisturbed", p - 32'h1, position);
		stop_test();
	end
endmodule : encoder_preset_param_access_tb_top
`default_nettype wire

/* File: test/plc_model.sv */
// PLC-side model: AXI4-Lite master with cyclic and acyclic request helpers.
// Assumes one clock; only the bench watchdog bounds a wait for the slave.
`default_nettype none
module plc_model
	import preset_param_pkg::*;
(
	// Clock
	input wire logic aclk,
	// Write channels
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// Read channels
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// Released payloads are inverted so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_araddr <= ~a;
		while (!s_axi_rvalid) @(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// Request bit stays set until std_clear, well over one I/O cycle
	task automatic std_request(input logic [31:0] v);
		logic [1:0] r;
		wr(OFF_STD_OUT, {1'b1, v[30:0]}, r);
	endtask : std_request
	task automatic std_clear();
		logic [1:0] r;
		wr(OFF_STD_OUT, 32'h0, r);
	endtask : std_clear
	// Header, address, value, then the go bit; lo fills ignored fields
	task automatic param_request(input logic [7:0] rf, input logic [7:0] id,
		input logic [15:0] num, input logic [15:0] lo, input logic [31:0] val);
		logic [1:0] r;
		wr(OFF_REQ_HDR, {16'h0001, id, rf}, r);
		wr(OFF_REQ_ADDR, {num, lo}, r);
		wr(OFF_REQ_VAL, val, r);
		wr(OFF_CTRL, 32'h3, r);
	endtask : param_request
endmodule : plc_model
`default_nettype wire
